/* hw/ucpd_pulse_cnt.v */
// Down counter that times each detection stage settle period.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module ucpd_pulse_cnt #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] count,
  output reg          done
);
  reg [W-1:0] left;
  // ****************************************************************
  // Countdown; done stands one cycle when it reaches zero
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      left <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      left <= count;
      done <= 1'b0;
    end else begin
      done <= (left == {{(W-1){1'b0}}, 1'b1});
      if (left != {W{1'b0}}) begin
        left <= left - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ucpd_pulse_cnt

/* hw/ucpd_regs.vh */
// Constants for the charger port detection block: codes, limits, timing.
// Assumes inclusion by ucpd_top.v only; ucpd_pulse_cnt.v does not include it.
`ifndef UCPD_REGS_VH
`define UCPD_REGS_VH
// ****************************************************************
// Source type codes
// ****************************************************************
`define UCPD_TYPE_NONE    4'h0
`define UCPD_TYPE_SDP     4'h1
`define UCPD_TYPE_CDP     4'h2
`define UCPD_TYPE_DCP     4'h3
`define UCPD_TYPE_HVDCP   4'h4
`define UCPD_TYPE_UNKNOWN 4'h5
`define UCPD_TYPE_NONSTD  4'h6
// ****************************************************************
// Current limits in mA
// ****************************************************************
`define UCPD_ILIM_SDP     12'h01F4
`define UCPD_ILIM_CDP     12'h05DC
`define UCPD_ILIM_DCP     12'h0CB2
`define UCPD_ILIM_HVDCP   12'h05DC
`define UCPD_ILIM_UNKNOWN 12'h0BB8
`define UCPD_ILIM_DIV1    12'h0834
`define UCPD_ILIM_DIV2    12'h07D0
`define UCPD_ILIM_DIV3    12'h03E8
`define UCPD_ILIM_DIV4    12'h0960
// ****************************************************************
// D+ drive levels (3 bits) and D- drive levels (3 bits)
// ****************************************************************
`define UCPD_DP_HIZ       3'h0
`define UCPD_DP_0V0       3'h1
`define UCPD_DP_0V6       3'h2
`define UCPD_DP_1V2       3'h3
`define UCPD_DP_2V0       3'h4
`define UCPD_DP_2V7       3'h5
`define UCPD_DP_3V3       3'h6
`define UCPD_DP_SHORT     3'h7
`define UCPD_DM_HIZ       3'h0
`define UCPD_DM_0V6       3'h1
`define UCPD_DM_1V2       3'h2
`define UCPD_DM_2V0       3'h3
`define UCPD_DM_2V7       3'h4
`define UCPD_DM_3V3       3'h5
// ****************************************************************
// Timing: stage settle time in ns, cycles at 5 ns
// ****************************************************************
`define UCPD_CLK_NS       5
`define UCPD_SETTLE_NS    100
`define UCPD_SETTLE_CYC   (`UCPD_SETTLE_NS / `UCPD_CLK_NS)
`endif

/* hw/ucpd_top.v */
// Port detection sequencer: classifies the first input source over D+/D-.
// Assumes analog window comparators and attach sense arrive asynchronously.
`timescale 1ns/1ps
`include "ucpd_regs.vh"
module ucpd_top #(
  parameter SETTLE = `UCPD_SETTLE_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        first_input_sense,
  input  wire        dcd_contact,
  input  wire        primary_hit,
  input  wire        secondary_hit,
  input  wire        hv_ack,
  input  wire [2:0]  dp_window,
  input  wire [2:0]  dm_window,
  input  wire [15:0] dp_adc,
  input  wire [15:0] dm_adc,
  input  wire        auto_source_detect_enable,
  input  wire        high_voltage_negotiation_enable,
  input  wire        request_nine_volt,
  input  wire        request_twelve_volt,
  input  wire        detection_complete_mask,
  input  wire        flag_clear,
  input  wire        drive_write,
  input  wire [2:0]  drive_dp_data,
  input  wire [2:0]  drive_dm_data,
  input  wire        limit_write,
  input  wire [11:0] limit_data,
  output reg         detection_in_progress,
  output reg         detection_complete_flag,
  output reg         int_pulse,
  output reg  [3:0]  source_type_code,
  output reg  [11:0] input_current_limit,
  output reg  [2:0]  positive_line_drive_level,
  output reg  [2:0]  negative_line_drive_level,
  output reg  [15:0] dp_voltage,
  output reg  [15:0] dm_voltage,
  output reg         hv_req_twelve,
  output reg         hv_req_nine
);
  // One-hot sequencer states
  localparam [7:0] S_IDLE = 8'h01, S_DCD = 8'h02, S_PRI = 8'h04, S_SEC = 8'h08;
  localparam [7:0] S_NSTD = 8'h10, S_HV12 = 8'h20, S_HV9 = 8'h40, S_DONE = 8'h80;
  // Window codes: bit0 low, bit1 mid, bit2 high window
  localparam [2:0] W_LO = 3'h1, W_MID = 3'h2, W_HI = 3'h4;

  reg [7:0]  state;
  reg [7:0]  next_state;
  // Eleven pin-side bits: attach, four comparator levels and two windows
  reg [10:0] s1;
  reg [10:0] s2;
  reg        attach_d;
  reg        load;
  wire       tick;
  wire       attach  = s2[0];
  wire       dcd     = s2[1];
  wire       pri     = s2[2];
  wire       sec     = s2[3];
  wire       hvack   = s2[4];
  wire [2:0] dpw     = s2[7:5];
  wire [2:0] dmw     = s2[10:8];
  wire       hv_ok   = high_voltage_negotiation_enable &
                       (request_nine_volt | request_twelve_volt);

  // Result table lookup shared by every branch that sets the type and limit
  function [15:0] result;
    input [3:0] code;
    input [2:0] dp;
    input [2:0] dm;
    begin
      result = {`UCPD_TYPE_UNKNOWN, `UCPD_ILIM_UNKNOWN};
      if (code == `UCPD_TYPE_NONSTD) begin
        if (dp == W_HI && dm == W_MID) result = {code, `UCPD_ILIM_DIV1};
        else if (dp == W_LO && dm == W_LO) result = {code, `UCPD_ILIM_DIV2};
        else if (dp == W_MID && dm == W_HI) result = {code, `UCPD_ILIM_DIV3};
        else if (dp == W_HI && dm == W_HI) result = {code, `UCPD_ILIM_DIV4};
      end else if (code == `UCPD_TYPE_SDP) result = {code, `UCPD_ILIM_SDP};
      else if (code == `UCPD_TYPE_CDP) result = {code, `UCPD_ILIM_CDP};
      else if (code == `UCPD_TYPE_DCP) result = {code, `UCPD_ILIM_DCP};
      else if (code == `UCPD_TYPE_HVDCP) result = {code, `UCPD_ILIM_HVDCP};
    end
  endfunction

  // ****************************************************************
  // Input synchronisers: two flops for every pin-side input
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 11'h000;
      s2 <= 11'h000;
    end else begin
      s1 <= {dm_window, dp_window, hv_ack, secondary_hit, primary_hit, dcd_contact,
             first_input_sense};
      s2 <= s1;
    end
  end

  ucpd_pulse_cnt #(.W(13)) u_settle (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (load),
    .count (SETTLE[12:0]),
    .done  (tick)
  );

  // ****************************************************************
  // Sequencer next state; each stage waits one settle period, S_DCD repeats it until contact is seen
  // ****************************************************************
  always @* begin
    next_state = state;
    load = 1'b0;
    case (state)
      S_IDLE: begin
        if (attach && !attach_d && auto_source_detect_enable) begin
          next_state = S_DCD;
          load = 1'b1;
        end
      end
      S_DCD: begin
        // Reload on every expiry so a slow contact cannot strand this stage
        if (tick) begin
          load = 1'b1;
          if (dcd) next_state = S_PRI;
        end
      end
      S_PRI: begin
        if (tick) begin
          next_state = pri ? S_SEC : S_NSTD;
          load = 1'b1;
        end
      end
      S_SEC: begin
        // Secondary only splits CDP from DCP; a DCP may go on to negotiate
        if (tick) begin
          if (sec && hv_ok) begin
            next_state = request_twelve_volt ? S_HV12 : S_HV9;
            load = 1'b1;
          end else begin
            next_state = S_DONE;
          end
        end
      end
      S_NSTD: if (tick) next_state = S_DONE;
      S_HV12: begin
        if (tick) begin
          next_state = hvack ? S_DONE : (request_nine_volt ? S_HV9 : S_DONE);
          load = !hvack && request_nine_volt;
        end
      end
      S_HV9: if (tick) next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    if (!attach && state != S_IDLE) next_state = S_IDLE;
  end

  // ****************************************************************
  // State, results, flags and host visible outputs
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      attach_d <= 1'b0;
      detection_in_progress <= 1'b0;
      detection_complete_flag <= 1'b0;
      int_pulse <= 1'b0;
      source_type_code <= `UCPD_TYPE_NONE;
      input_current_limit <= `UCPD_ILIM_UNKNOWN;
      positive_line_drive_level <= `UCPD_DP_HIZ;
      negative_line_drive_level <= `UCPD_DM_HIZ;
      dp_voltage <= 16'h0000;
      dm_voltage <= 16'h0000;
      hv_req_twelve <= 1'b0;
      hv_req_nine <= 1'b0;
    end else begin
      state <= next_state;
      attach_d <= attach;
      int_pulse <= 1'b0;
      dp_voltage <= dp_adc;
      dm_voltage <= dm_adc;
      hv_req_twelve <= 1'b0;
      hv_req_nine <= 1'b0;
      if (limit_write) input_current_limit <= limit_data;
      // Drive writes dropped mid-detection so the host cannot upset the probe
      if (drive_write && !(attach && detection_in_progress)) begin
        positive_line_drive_level <= drive_dp_data;
        negative_line_drive_level <= drive_dm_data;
      end
      if (flag_clear) detection_complete_flag <= 1'b0;
      if (state == S_IDLE && next_state == S_DCD) detection_in_progress <= 1'b1;
      if (state == S_SEC && tick) begin
        if (sec && hv_ok) begin
          // DCP limit stands while the handshake runs
          {source_type_code, input_current_limit} <= result(`UCPD_TYPE_DCP, 3'h0, 3'h0);
        end else begin
          {source_type_code, input_current_limit} <=
            result(sec ? `UCPD_TYPE_DCP : `UCPD_TYPE_CDP, 3'h0, 3'h0);
        end
      end
      if (state == S_PRI && tick && !pri) begin
        // Only the primary miss drops to the divider checks
        {source_type_code, input_current_limit} <= result(`UCPD_TYPE_SDP, 3'h0, 3'h0);
      end
      if (state == S_NSTD && tick && (dpw != 3'h0 || dmw != 3'h0)) begin
        {source_type_code, input_current_limit} <=
          result((dpw == W_MID && dmw == W_MID) ? `UCPD_TYPE_UNKNOWN : `UCPD_TYPE_NONSTD,
                 dpw, dmw);
      end
      // Request lines trail the state by one cycle, like the completion flag and interrupt
      if (state == S_HV12) hv_req_twelve <= 1'b1;
      if (state == S_HV9) hv_req_nine <= 1'b1;
      if ((state == S_HV12 || state == S_HV9) && tick && hvack) begin
        {source_type_code, input_current_limit} <= result(`UCPD_TYPE_HVDCP, 3'h0, 3'h0);
      end
      if (state == S_DONE) begin
        detection_in_progress <= 1'b0;
        detection_complete_flag <= 1'b1;
        int_pulse <= !detection_complete_mask;
      end
      if (!attach) detection_in_progress <= 1'b0;
    end
  end
endmodule // ucpd_top

/* test/ucpd_monitor.sv */
// Port checker for ucpd_top: handshake, drive fields and completion.
// Assumes bind into ucpd_top; ports match the design's names.
`timescale 1ns/1ps
module ucpd_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        first_input_sense,
  input wire        auto_source_detect_enable,
  input wire        high_voltage_negotiation_enable,
  input wire        request_nine_volt,
  input wire        request_twelve_volt,
  input wire        detection_complete_mask,
  input wire        drive_write,
  input wire [2:0]  drive_dp_data,
  input wire [2:0]  drive_dm_data,
  input wire [15:0] dp_adc,
  input wire [15:0] dm_adc,
  input wire        detection_in_progress,
  input wire        detection_complete_flag,
  input wire        int_pulse,
  input wire [2:0]  positive_line_drive_level,
  input wire [2:0]  negative_line_drive_level,
  input wire [15:0] dp_voltage,
  input wire [15:0] dm_voltage,
  input wire        hv_req_twelve,
  input wire        hv_req_nine
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_int_done: assert property (int_pulse |-> detection_complete_flag &&
    !detection_in_progress && !detection_complete_mask) else $error("int without done");
  a_int_single: assert property (int_pulse |=> !int_pulse) else $error("int too long");
  a_flag_int: assert property ($rose(detection_complete_flag) &&
    !detection_complete_mask |-> int_pulse) else $error("no int on done");
  a_adc_copy: assert property ($past(rst_n) |-> dp_voltage == $past(dp_adc))
    else $error("adc copy");
  a_adc_copy_dm: assert property ($past(rst_n) |-> dm_voltage == $past(dm_adc))
    else $error("dm adc copy");
  a_drive_drop: assert property (drive_write && first_input_sense &&
    detection_in_progress |=> $stable(positive_line_drive_level) &&
    $stable(negative_line_drive_level)) else $error("drive taken while busy");
  a_drive_take: assert property (drive_write && !first_input_sense &&
    !detection_in_progress |=> positive_line_drive_level == $past(drive_dp_data) &&
    negative_line_drive_level == $past(drive_dm_data)) else $error("drive lost");
  a_twelve_gate: assert property (hv_req_twelve |->
    high_voltage_negotiation_enable && request_twelve_volt) else $error("12V ungated");
  a_nine_gate: assert property (hv_req_nine |-> high_voltage_negotiation_enable &&
    request_nine_volt && !hv_req_twelve) else $error("9V ungated");
  a_auto_off: assert property (!auto_source_detect_enable &&
    !detection_in_progress |=> !detection_in_progress) else $error("ran with auto off");
endmodule // ucpd_monitor
bind ucpd_top ucpd_monitor i_ucpd_monitor (.*);

/* test/ucpd_port_model.sv */
// Adapter model on D+/D-: kind picks what the comparators report.
// Assumes the bench holds kind steady while first_input_sense is high.
`timescale 1ns/1ps
module ucpd_port_model (
  input  wire       clk,
  input  wire       first_input_sense,
  input  wire [3:0] kind,
  input  wire [3:0] ack_wait,
  input  wire       hv_req_twelve,
  input  wire       hv_req_nine,
  output reg        dcd_contact = 1'b0,
  output reg        hv_ack = 1'b0,
  output wire       primary_hit,
  output wire       secondary_hit,
  output reg  [2:0] dp_window,
  output reg  [2:0] dm_window
);
  reg [3:0] n = 4'h0;
  // ********************
  // Port behaviour
  // ********************
  // Contact lags the plug; only kind 4 acks, and only after ack_wait
  always @(posedge clk) begin
    dcd_contact <= first_input_sense;
    n <= (hv_req_twelve | hv_req_nine) ? n + 4'h1 : 4'h0;
    hv_ack <= first_input_sense && kind == 4'h4 && n > ack_wait;
  end
  // A CDP stays a CDP: every run ends long before the host must enumerate
  assign primary_hit = first_input_sense && kind > 4'h1 && kind < 4'h5;
  assign secondary_hit = first_input_sense && (kind == 4'h3 || kind == 4'h4);
  // Divider windows; a detached plug shows no window at all
  always @* begin
    case (first_input_sense ? kind : 4'h0)
      4'h5: {dp_window, dm_window} = 6'h12;
      4'h6: {dp_window, dm_window} = 6'h22;
      4'h7: {dp_window, dm_window} = 6'h09;
      4'h8: {dp_window, dm_window} = 6'h14;
      4'h9: {dp_window, dm_window} = 6'h24;
      default: {dp_window, dm_window} = 6'h00;
    endcase
  end
endmodule // ucpd_port_model

/* test/ucpd_top_tb_top.sv */
// Bench for ucpd_top with the adapter model on the D+/D- side.
// Assumes design, checker and model are compiled before this file.
`timescale 1ns/1ps
module ucpd_top_tb_top;
  // ********************
  // Signals and parts
  // ********************
  reg         clk = 0, rst_n = 0, first_input_sense = 0, auto_source_detect_enable = 1;
  reg         high_voltage_negotiation_enable = 0, request_nine_volt = 1;
  reg         request_twelve_volt = 1, detection_complete_mask = 0, flag_clear = 0;
  reg         drive_write = 0, limit_write = 0, seen12, seen9, bad_ord, seen_dcp;
  reg  [2:0]  drive_dp_data = 3'h0, drive_dm_data = 3'h0;
  reg  [11:0] limit_data = 12'h000;
  reg  [15:0] dp_adc = 16'h0000, dm_adc = 16'h0000;
  reg  [3:0]  kind = 4'h0, ack_wait = 4'h6;
  wire        dcd_contact, primary_hit, secondary_hit, hv_ack, detection_in_progress;
  wire        detection_complete_flag, int_pulse, hv_req_twelve, hv_req_nine;
  wire [2:0]  dp_window, dm_window, positive_line_drive_level, negative_line_drive_level;
  wire [3:0]  source_type_code;
  wire [11:0] input_current_limit;
  wire [15:0] dp_voltage, dm_voltage;
  integer     errors = 0, n_tests = 0, n_int = 0;
  // Settle long enough that a synchronised handshake ack lands inside its stage
  ucpd_top #(.SETTLE(12)) i_ucpd_top (.*);
  ucpd_port_model i_ucpd_port_model (.*);
  // Clock and a converter word that changes every cycle
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    dp_adc <= #1 dp_adc + 16'h0101;
    dm_adc <= #1 ~dp_adc;
    n_int <= n_int + (int_pulse === 1'b1);
    seen12 <= seen12 | (hv_req_twelve === 1'b1);
    seen9 <= seen9 | (hv_req_nine === 1'b1);
    bad_ord <= bad_ord | (hv_req_nine === 1'b1 && !seen12);
    seen_dcp <= seen_dcp | (detection_in_progress === 1'b1 && input_current_limit === 12'h0CB2);
  end
  // ********************
  // Helpers
  // ********************
  task tick; begin @(posedge clk); #1; end endtask
  task clr; begin seen12 = 0; seen9 = 0; bad_ord = 0; seen_dcp = 0; end endtask
  task ck(input string s, input logic [15:0] got, input logic [15:0] exp); begin
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s exp %h got %h", s, exp, got);
    end
  end endtask
  // Plug in, wait for done under a bound, check the result, unplug
  task run(input [3:0] k, input [3:0] c, input [11:0] l);
    integer i;
    begin
      kind = k;
      first_input_sense = 1;
      for (i = 0; i < 300 && detection_complete_flag !== 1'b1; i = i + 1) tick;
      ck("done", detection_complete_flag, 1);
      ck("busy", detection_in_progress, 0);
      ck("code", source_type_code, c);
      ck("limit", input_current_limit, l);
      first_input_sense = 0;
      flag_clear = 1;
      tick;
      flag_clear = 0;
      repeat (4) tick;
      ck("flag", detection_complete_flag, 0);
    end
  endtask
  task summarize; begin
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  // ********************
  // Scenarios
  // ********************
  task t_types;
    integer i, m;
    reg [19:0] e;
    begin
      clr;
      for (i = 0; i < 8; i = i + 1) begin
        case (i)
          0: e = 20'h1_11F4; 1: e = 20'h2_25DC; 2: e = 20'h3_3CB2; 3: e = 20'h5_5BB8;
          4: e = 20'h6_6834; 5: e = 20'h7_67D0; 6: e = 20'h8_63E8; default: e = 20'h9_6960;
        endcase
        m = n_int;
        run(e[19:16], e[15:12], e[11:0]);
        ck("int", n_int - m, 1);
      end
      ck("hv off", {seen12, seen9}, 0);
    end
  endtask
  task t_mask;
    integer m;
    begin
      detection_complete_mask = 1;
      m = n_int;
      run(4'h1, 4'h1, 12'h01F4);
      ck("masked int", n_int - m, 0);
      detection_complete_mask = 0;
    end
  endtask
  // Nine only, slow ack, then both with no ack
  task t_hv; begin
    clr;
    high_voltage_negotiation_enable = 1;
    request_twelve_volt = 0;
    run(4'h4, 4'h4, 12'h05DC);
    ck("dcp first", seen_dcp, 1);
    ck("nine only", {seen12, seen9}, 1);
    clr;
    request_twelve_volt = 1;
    run(4'h3, 4'h3, 12'h0CB2);
    ck("order", {seen12, seen9, bad_ord}, 6);
    high_voltage_negotiation_enable = 0;
  end endtask
  task t_auto; begin
    auto_source_detect_enable = 0;
    limit_write = 1;
    limit_data = 12'h0123;
    tick;
    limit_write = 0;
    kind = 4'h1;
    first_input_sense = 1;
    repeat (100) tick;
    ck("skipped", {detection_in_progress, detection_complete_flag}, 0);
    ck("limit kept", input_current_limit, 12'h0123);
    first_input_sense = 0;
    repeat (4) tick;
    auto_source_detect_enable = 1;
  end endtask
  task t_drive;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        drive_write = 1;
        drive_dp_data = i[2:0];
        drive_dm_data = i[2:0] % 3'h6;
        tick;
        drive_write = 0;
        tick;
        ck("dp", positive_line_drive_level, i[2:0]);
        ck("dm", negative_line_drive_level, i[2:0] % 3'h6);
      end
      first_input_sense = 1;
      for (i = 0; i < 40 && detection_in_progress !== 1'b1; i = i + 1) tick;
      drive_write = 1;
      drive_dp_data = 3'h2;
      drive_dm_data = 3'h4;
      tick;
      drive_write = 0;
      tick;
      ck("dp held", {positive_line_drive_level, negative_line_drive_level}, 6'h39);
      run(4'h1, 4'h1, 12'h01F4);
    end
  endtask
  // Watchdog, well beyond the longest expected run
  initial begin #300000; errors = errors + 1; summarize; end
  initial begin
    clr;
    repeat (20) tick;
    rst_n = 1;
    tick;
    ck("reset", {source_type_code, input_current_limit}, 16'h0BB8);
    ck("reset drive", {positive_line_drive_level, negative_line_drive_level}, 0);
    t_types;
    t_mask;
    t_hv;
    t_auto;
    t_drive;
    summarize;
  end
endmodule // ucpd_top_tb_top
